// >>> common/wff_pkg.sv
// Constants for the wake-up frame filter register bank.
// Assumes an 8-bit paged host bus and a byte-wide receive stream.
package wff_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [1:0]  PAGE_WAKE      = 2'h3;
  localparam logic [4:0]  OFS_MASK0      = 5'h01;
  localparam logic [4:0]  OFS_MASK3      = 5'h04;
  localparam logic [4:0]  OFS_CRC_LO     = 5'h05;
  localparam logic [4:0]  OFS_CRC_HI     = 5'h06;
  localparam logic [4:0]  OFS_START      = 5'h07;
  localparam logic [4:0]  OFS_LAST       = 5'h08;
  localparam logic [4:0]  OFS_CMD        = 5'h09;
  localparam logic [4:0]  OFS_WAKE_CTL   = 5'h0a;
  localparam logic [4:0]  OFS_PWR_MGMT   = 5'h0b;
  localparam logic [4:0]  OFS_NONE       = 5'h00;

  localparam logic [31:0] REG_RESET      = 32'h0000_0000;
  localparam logic [31:0] CMD_WR_MASK    = 32'h000f_ffff;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int          NUM_FILT       = 4;
  localparam int          CMD_EN_BIT     = 0;
  localparam int          CMD_DA_BIT     = 1;
  localparam int          CMD_MC_BIT     = 2;
  localparam int          CHAIN_LSB      = 16;
  localparam int          WAKE_EN_BIT    = 1;
  localparam int          WAKE_SEEN_BIT  = 5;
  localparam int          MASK_BYTES     = 32;

  // ****************************************************************
  // CRC and frame counting
  // ****************************************************************
  localparam logic [15:0] CRC_POLY       = 16'h8005;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam int          CNT_W          = 10;
  localparam logic [CNT_W-1:0] CNT_MAX   = 10'h3ff;

endpackage : wff_pkg

// >>> rtl/wff_crc16.sv
// One running CRC-16 accumulator, fed one byte per accepted cycle.
// Assumes clear and enable are never needed in the same cycle.
`timescale 1ns/10ps
module wff_crc16
  import wff_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        clear,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;

  // ****************************************************************
  // Byte update, most significant bit first
  // ****************************************************************
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 7; b >= 0; b--) begin
      if (r[15] ^ d[b]) begin
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction : crc_byte

  always_comb begin
    crc_d = crc_byte(crc_q, data);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      crc_q <= CRC_INIT;
    end else if (clear) begin
      crc_q <= CRC_INIT;
    end else if (en) begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;

endmodule : wff_crc16

// >>> rtl/wff_regs.sv
// Wake-up frame filter registers and frame matching.
// Assumes a byte-wide host bus on page 3 and a receive stream that
// brackets each frame with one-cycle start and end pulses.
`timescale 1ns/10ps
module wff_regs
  import wff_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [1:0]  host_page,
  input  wire logic [4:0]  host_addr,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  input  wire logic        rx_sof,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_eof,
  input  wire logic        rx_da_match,
  input  wire logic        rx_mc_match,
  output logic             pattern_wake_seen_flag,
  output logic             wake_frame_pulse,
  output logic      [3:0]  filter_hit
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [31:0]      byte_mask_q [NUM_FILT];
  logic [31:0]      crc_lo_q;
  logic [31:0]      crc_hi_q;
  logic [31:0]      start_q;
  logic [31:0]      last_q;
  logic [31:0]      cmd_q;
  logic             wake_en_q;
  logic             seen_q;
  logic [1:0]       lane_q;
  logic [4:0]       prev_ofs_q;
  logic [7:0]       rdata_q;
  logic             pulse_q;
  logic [3:0]       hit_q;
  logic [CNT_W-1:0] cnt_q;
  logic             in_frame_q;

  logic             page_ok;
  logic             word_reg;
  logic             wr_word;
  logic [1:0]       lane;
  logic [31:0]      word_sel;
  logic [15:0]      crc_now [NUM_FILT];
  logic [3:0]       take;
  logic [3:0]       ok;
  logic [3:0]       hit;
  logic [2:0]       chain;
  logic             clr_seen;

  // ****************************************************************
  // Host access decode
  // ****************************************************************
  assign page_ok  = (host_page == PAGE_WAKE);
  assign word_reg = page_ok && (host_addr >= OFS_MASK0) && (host_addr <= OFS_CMD);
  assign wr_word  = host_wr && word_reg;
  // Successive accesses to one offset walk the byte lanes upward
  assign lane     = (host_addr == prev_ofs_q) ? lane_q : 2'h0;

  function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] l,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = w;
    r[l*8 +: 8] = b;
    return r;
  endfunction : put_byte

  always_comb begin
    word_sel = REG_RESET;
    case (host_addr)
      OFS_CRC_LO: word_sel = crc_lo_q;
      OFS_CRC_HI: word_sel = crc_hi_q;
      OFS_START:  word_sel = start_q;
      OFS_LAST:   word_sel = last_q;
      OFS_CMD:    word_sel = cmd_q;
      default: begin
        if (host_addr >= OFS_MASK0 && host_addr <= OFS_MASK3) begin
          word_sel = byte_mask_q[2'(host_addr - OFS_MASK0)];
        end
      end
    endcase
  end

  // ****************************************************************
  // Byte lane sequencer
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lane_q     <= 2'h0;
      prev_ofs_q <= OFS_NONE;
    end else if (host_wr || host_rd) begin
      if (word_reg) begin
        lane_q     <= lane + 2'h1;
        prev_ofs_q <= host_addr;
      end else begin
        lane_q     <= 2'h0;
        prev_ofs_q <= OFS_NONE;
      end
    end
  end

  // ****************************************************************
  // Filter registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_FILT; i++) begin
        byte_mask_q[i] <= REG_RESET;
      end
      crc_lo_q <= REG_RESET;
      crc_hi_q <= REG_RESET;
      start_q  <= REG_RESET;
      last_q   <= REG_RESET;
      cmd_q    <= REG_RESET;
    end else if (wr_word) begin
      case (host_addr)
        OFS_CRC_LO: crc_lo_q <= put_byte(crc_lo_q, lane, host_wdata);
        OFS_CRC_HI: crc_hi_q <= put_byte(crc_hi_q, lane, host_wdata);
        OFS_START:  start_q  <= put_byte(start_q, lane, host_wdata);
        OFS_LAST:   last_q   <= put_byte(last_q, lane, host_wdata);
        OFS_CMD:    cmd_q    <= put_byte(cmd_q, lane, host_wdata) & CMD_WR_MASK;
        default: begin
          for (int i = 0; i < NUM_FILT; i++) begin
            if (host_addr == OFS_MASK0 + 5'(i)) begin
              byte_mask_q[i] <= put_byte(byte_mask_q[i], lane, host_wdata);
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Wake control and seen flag
  // ****************************************************************
  assign clr_seen = host_wr && page_ok &&
                    ((host_addr == OFS_PWR_MGMT) ||
                     (host_addr == OFS_WAKE_CTL && host_wdata[WAKE_SEEN_BIT]));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wake_en_q <= 1'b0;
    end else if (host_wr && page_ok && host_addr == OFS_WAKE_CTL) begin
      wake_en_q <= host_wdata[WAKE_EN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seen_q <= 1'b0;
    end else if (pulse_q) begin
      seen_q <= 1'b1;
    end else if (clr_seen) begin
      seen_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (host_rd) begin
      if (word_reg) begin
        rdata_q <= word_sel[lane*8 +: 8];
      end else if (page_ok && host_addr == OFS_WAKE_CTL) begin
        rdata_q <= 8'(({7'h00, seen_q} << WAKE_SEEN_BIT) |
                      ({7'h00, wake_en_q} << WAKE_EN_BIT));
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // Frame position
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q      <= '0;
      in_frame_q <= 1'b0;
    end else if (rx_sof) begin
      cnt_q      <= '0;
      in_frame_q <= 1'b1;
    end else if (rx_eof) begin
      in_frame_q <= 1'b0;
    end else if (rx_valid && in_frame_q && cnt_q != CNT_MAX) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Byte is inside the window from the start offset and selected
  function automatic logic byte_taken(input logic [CNT_W-1:0] pos, input logic [7:0] ofs,
                                      input logic [31:0] mask, input logic [7:0] lastb);
    logic [CNT_W-1:0] base;
    logic [CNT_W-1:0] rel;
    base = {1'b0, ofs, 1'b0};
    rel  = pos - base;
    return (pos >= base) && (rel < CNT_W'(MASK_BYTES)) &&
           (rel <= CNT_W'(lastb)) && mask[rel[4:0]];
  endfunction : byte_taken

  // ****************************************************************
  // Per-filter CRC and match
  // ****************************************************************
  for (genvar g = 0; g < NUM_FILT; g++) begin : g_filt
    assign take[g] = rx_valid && in_frame_q &&
                     byte_taken(cnt_q, start_q[g*8 +: 8], byte_mask_q[g],
                                last_q[g*8 +: 8]);

    wff_crc16 u_crc (
      .mclk  (mclk),
      .nrst  (nrst),
      .clear (rx_sof),
      .en    (take[g]),
      .data  (rx_data),
      .crc   (crc_now[g])
    );

    logic [15:0] want;
    assign want  = (g < 2) ? crc_lo_q[(g%2)*16 +: 16] : crc_hi_q[(g%2)*16 +: 16];
    assign ok[g] = cmd_q[g*4 + CMD_EN_BIT] && (crc_now[g] == want) &&
                   (!cmd_q[g*4 + CMD_DA_BIT] || rx_da_match) &&
                   (!cmd_q[g*4 + CMD_MC_BIT] || rx_mc_match);
  end

  assign chain = cmd_q[CHAIN_LSB +: 3];

  // A chained pair only counts when both of its members match
  always_comb begin
    hit = ok;
    for (int i = 0; i < NUM_FILT - 1; i++) begin
      if (chain[i] && !(ok[i] && ok[i+1])) begin
        hit[i]   = 1'b0;
        hit[i+1] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pulse_q <= 1'b0;
      hit_q   <= 4'h0;
    end else if (rx_eof && in_frame_q) begin
      pulse_q <= wake_en_q && (hit != 4'h0);
      hit_q   <= hit;
    end else begin
      pulse_q <= 1'b0;
    end
  end

  assign host_rdata             = rdata_q;
  assign pattern_wake_seen_flag = seen_q;
  assign wake_frame_pulse       = pulse_q;
  assign filter_hit             = hit_q;

endmodule : wff_regs

// >>> verification/wff_host_model.sv
// Host model: paged byte-wide register accesses.
// Drives the bank's host inputs; released address and data lines toggle.
`timescale 1ns/10ps
module wff_host_model
  import wff_pkg::*;
(
  input  wire logic       mclk,
  output logic      [1:0] host_page = 2'h0,
  output logic      [4:0] host_addr = 5'h00,
  output logic            host_wr = 1'b0,
  output logic            host_rd = 1'b0,
  output logic      [7:0] host_wdata = 8'h00
);
  // ****
  // Access task
  // ****
  task automatic acc(input logic w, input logic [1:0] p, input logic [4:0] a,
                     input logic [31:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      host_wr    <= w;
      host_rd    <= !w;
      host_page  <= p;
      host_addr  <= a;
      host_wdata <= d[8*i+:8];
    end
    @(posedge mclk);
    host_wr    <= 1'b0;
    host_rd    <= 1'b0;
    host_addr  <= ~host_addr;
    host_wdata <= ~host_wdata;
  endtask : acc
endmodule : wff_host_model

// >>> verification/wff_regs_checker.sv
// Port assertions for the wake-up filter bank.
// Bound into every wff_regs; sees its ports only.
`timescale 1ns/10ps
module wff_regs_checker
  import wff_pkg::*;
(
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic [1:0] host_page,
  input wire logic [4:0] host_addr,
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic       rx_eof,
  input wire logic       pattern_wake_seen_flag,
  input wire logic       wake_frame_pulse,
  input wire logic [3:0] filter_hit
);
  // ****
  // Wake enable shadow
  // ****
  logic en_q;
  wire  ctl_wr = host_wr && host_page == PAGE_WAKE;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      en_q <= 1'b0;
    end else if (ctl_wr && host_addr == OFS_WAKE_CTL) begin
      en_q <= host_wdata[WAKE_EN_BIT];
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // ****
  // Assertions
  // ****
  a_pulse_eof: assert property (wake_frame_pulse |-> $past(rx_eof))
    else $error("pulse without frame end");
  a_pulse_enabled: assert property (wake_frame_pulse |-> $past(en_q))
    else $error("pulse while disabled");
  a_pulse_hit: assert property (wake_frame_pulse |-> filter_hit != 4'h0)
    else $error("pulse without hit");
  a_pulse_single: assert property (wake_frame_pulse |=> !wake_frame_pulse)
    else $error("pulse too long");
  a_flag_set: assert property (wake_frame_pulse |=> pattern_wake_seen_flag)
    else $error("flag not set");
  a_flag_cause: assert property ($rose(pattern_wake_seen_flag) |-> $past(wake_frame_pulse))
    else $error("flag set alone");
  a_flag_clear: assert property (
    ctl_wr && host_addr == OFS_PWR_MGMT && !wake_frame_pulse |=> !pattern_wake_seen_flag)
    else $error("flag kept after clear");
  a_hit_holds: assert property (!rx_eof |=> $stable(filter_hit))
    else $error("hit changed without eof");
  a_rd_refused: assert property (host_rd && host_page != PAGE_WAKE |=> host_rdata == 8'h00)
    else $error("foreign page read not zero");
  a_rd_holds: assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data moved");
  c_wake: cover property (wake_frame_pulse);
  c_clear: cover property (pattern_wake_seen_flag ##1 !pattern_wake_seen_flag);
  c_multi: cover property ($countones(filter_hit) > 1);
endmodule : wff_regs_checker

bind wff_regs wff_regs_checker u_chk (.mclk, .nrst, .host_page, .host_addr, .host_wr,
  .host_rd, .host_wdata, .host_rdata, .rx_eof, .pattern_wake_seen_flag, .wake_frame_pulse,
  .filter_hit);

// >>> verification/wff_regs_tb_top.sv
// Bench for the filter bank: register map, then random frames.
// Host model drives the bus; expected results queue up for a watcher.
`timescale 1ns/10ps
module wff_regs_tb_top
  import wff_pkg::*;
;
  localparam int FLEN = 40;
  logic             mclk = 1'b0, nrst = 1'b0, host_wr, host_rd, flag, pulse, en;
  logic             rx_sof = 1'b0, rx_valid = 1'b0, rx_eof = 1'b0;
  logic             rx_da_match = 1'b0, rx_mc_match = 1'b0, rd_d = 1'b0, eof_d = 1'b0;
  logic             sticky = 1'b0;
  logic [1:0]       host_page, dm;
  logic [4:0]       host_addr;
  logic [7:0]       host_wdata, host_rdata, rx_data = 8'h00;
  logic [31:0]      seed = 32'hb8dc, v;
  logic [31:0]      wv [10];
  logic [7:0]       frm [FLEN];
  logic [3:0][31:0] msk;
  logic [3:0][15:0] crc;
  logic [3:0][7:0]  ofs, lst;
  logic [3:0][3:0]  cmd;
  logic [3:0]       h, g, hit;
  logic [2:0]       ch;
  logic [7:0]       rq [$];
  logic [4:0]       fq [$];
  int               n_mismatch = 0, cmp_count = 0, cyc = 0;

  always #5 mclk = ~mclk;
  wff_host_model host (.mclk, .host_page, .host_addr, .host_wr, .host_rd, .host_wdata);
  wff_regs DUT (.mclk, .nrst, .host_page, .host_addr, .host_wr, .host_rd, .host_wdata,
    .host_rdata, .rx_sof, .rx_valid, .rx_data, .rx_eof, .rx_da_match, .rx_mc_match,
    .pattern_wake_seen_flag(flag), .wake_frame_pulse(pulse), .filter_hit(hit));

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [15:0] fcrc(input int i);
    logic [15:0] c;
    int          r;
    c = CRC_INIT;
    for (int p = 0; p < FLEN; p++) begin
      r = p - 2 * int'(ofs[i]);
      if (r >= 0 && r < 32 && r <= int'(lst[i]) && msk[i][r]) begin
        for (int b = 7; b >= 0; b--) begin
          c = {c[14:0], 1'b0} ^ ((c[15] ^ frm[p][b]) ? CRC_POLY : 16'h0000);
        end
      end
    end
    return c;
  endfunction : fcrc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdw(input logic [1:0] p, input logic [4:0] a, input logic [31:0] e, int n);
    for (int i = 0; i < n; i++) rq.push_back(e[8*i+:8]);
    host.acc(1'b0, p, a, 32'h0, n);
  endtask : rdw
  task automatic send();
    @(posedge mclk) rx_sof <= 1'b1;
    for (int p = 0; p < FLEN; p++) begin
      @(posedge mclk);
      rx_sof   <= 1'b0;
      rx_valid <= 1'b1;
      rx_data  <= frm[p];
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
    rx_eof   <= 1'b1;
    @(posedge mclk) rx_eof <= 1'b0;
  endtask : send
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  // ****
  // Watcher and timeout
  // ****
  always @(posedge mclk) begin
    rd_d  <= host_rd;
    eof_d <= rx_eof;
    if (rd_d) chk(host_rdata, rq.pop_front());
    if (eof_d) chk({3'h0, pulse, hit}, {3'h0, fq.pop_front()});
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ****
  // Tests
  // ****
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    for (int a = 1; a < 10; a++) rdw(PAGE_WAKE, 5'(a), REG_RESET, 4);
    rdw(PAGE_WAKE, OFS_WAKE_CTL, REG_RESET, 1);
    for (int a = 1; a < 10; a++) begin
      v = rnd();
      wv[a] = (a == 9) ? v & CMD_WR_MASK : v;
      host.acc(1'b1, PAGE_WAKE, 5'(a), v, 4);
      rdw(PAGE_WAKE, 5'(a), wv[a], 4);
    end
    host.acc(1'b1, 2'h2, OFS_MASK0, 32'hff, 1);
    rdw(2'h2, OFS_MASK0, REG_RESET, 1);
    rdw(PAGE_WAKE, OFS_MASK0, wv[1], 4);
    host.acc(1'b1, PAGE_WAKE, OFS_START, 32'h5aa5, 2);
    rdw(PAGE_WAKE, OFS_NONE, REG_RESET, 1);
    rdw(PAGE_WAKE, OFS_START, {wv[7][31:16], 16'h5aa5}, 4);
    $display("test registers done");
    for (int t = 0; t < 16; t++) begin
      for (int p = 0; p < FLEN; p++) begin
        v = rnd();
        frm[p] = v[7:0];
      end
      v = rnd();
      en = v[27];
      dm = v[29:28];
      ch = v[26] ? {1'b0, v[24], 1'b0} : {v[24], 1'b0, v[25]};
      for (int i = 0; i < 4; i++) begin
        msk[i] = rnd();
        v = rnd();
        ofs[i] = {6'h00, v[1:0]};
        lst[i] = v[15:8] & 8'h3f;
        cmd[i] = v[19:16];
        crc[i] = fcrc(i) ^ {15'h0, v[20] & v[21]};
        h[i] = cmd[i][0] && !(v[20] && v[21]) && (!cmd[i][1] || dm[0])
          && (!cmd[i][2] || dm[1]);
      end
      g = h;
      for (int k = 0; k < 3; k++) begin
        if (ch[k] && !(h[k] && h[k+1])) begin
          g[k]   = 1'b0;
          g[k+1] = 1'b0;
        end
      end
      for (int i = 0; i < 4; i++) host.acc(1'b1, PAGE_WAKE, OFS_MASK0 + 5'(i), msk[i], 4);
      host.acc(1'b1, PAGE_WAKE, OFS_CRC_LO, crc[1:0], 4);
      host.acc(1'b1, PAGE_WAKE, OFS_CRC_HI, crc[3:2], 4);
      host.acc(1'b1, PAGE_WAKE, OFS_START, ofs, 4);
      host.acc(1'b1, PAGE_WAKE, OFS_LAST, lst, 4);
      host.acc(1'b1, PAGE_WAKE, OFS_CMD, {13'h0000, ch, cmd}, 4);
      host.acc(1'b1, PAGE_WAKE, OFS_WAKE_CTL, {30'h0, en, 1'b0}, 1);
      rx_da_match <= dm[0];
      rx_mc_match <= dm[1];
      fq.push_back({en && |g, g});
      send();
      sticky = sticky | (en && |g);
      rdw(PAGE_WAKE, OFS_WAKE_CTL, {26'h0, sticky, 3'h0, en, 1'b0}, 1);
      chk({7'h00, flag}, {7'h00, sticky});
      if (t % 3 != 2) begin
        host.acc(1'b1, PAGE_WAKE, (t % 3 == 0) ? OFS_PWR_MGMT : OFS_WAKE_CTL, 32'h20, 1);
        sticky = 1'b0;
        @(posedge mclk);
        chk({7'h00, flag}, 8'h00);
      end
    end
    $display("test frames done");
    repeat (4) @(posedge mclk);
    finish_test();
  end
endmodule : wff_regs_tb_top
